// ---- core/ltl_params.svh ----
`ifndef LTL_PARAMS_SVH
`define LTL_PARAMS_SVH

// Register indices; the byte address is four times the index.
`define LTL_IDX_RESULT        7'h00
`define LTL_IDX_CONFIG        7'h01
`define LTL_IDX_LOWER         7'h02
`define LTL_IDX_UPPER         7'h03
`define LTL_IDX_IRQ_STATUS    7'h10
`define LTL_IDX_IRQ_MASK      7'h11
`define LTL_IDX_MAKER         7'h7E
`define LTL_IDX_PART          7'h7F

// Reset values.
`define LTL_LOWER_RESET       16'h0000
`define LTL_UPPER_RESET       16'hBFFF
`define LTL_CONFIG_RESET      16'hC010

// Threshold and result field positions.
`define LTL_EXP_MSB           15
`define LTL_EXP_LSB           12
`define LTL_MAN_MSB           11
`define LTL_MAN_LSB           0

// Configuration field positions.
`define LTL_CFG_FC_MSB        1
`define LTL_CFG_FC_LSB        0
`define LTL_CFG_MASK_BIT      2
`define LTL_CFG_POL_BIT       3
`define LTL_CFG_LATCH_BIT     4
`define LTL_CFG_BELOW_BIT     5
`define LTL_CFG_ABOVE_BIT     6
`define LTL_CFG_RANGE_MSB     15
`define LTL_CFG_RANGE_LSB     12
`define LTL_CFG_WRITE_MASK    16'hF01F

// Interrupt status bit positions.
`define LTL_IRQ_ABOVE_BIT     0
`define LTL_IRQ_BELOW_BIT     1
`define LTL_IRQ_DONE_BIT      2

// Comparison scale.
`define LTL_MAX_EXP           4'hB
`define LTL_MASK_RANGE_LIMIT  4'hC
`define LTL_FULL_SCALE        23'h7FFFFF

// Fault counting ceiling, the largest selectable count.
`define LTL_MAX_FAULTS        4'h8

`endif

// ---- core/ltl_pkg.sv ----
package ltl_pkg;

   typedef enum logic [0:0] {
      LTL_BUS_IDLE = 1'b0,
      LTL_BUS_ACK  = 1'b1
   } ltl_bus_t;

   typedef struct packed {
      ltl_bus_t     bus;
      logic [31:0]  readdata;
      logic [15:0]  lower_threshold;
      logic [15:0]  upper_threshold;
      logic [15:0]  config_word;
      logic [15:0]  result;
      logic [3:0]   above_cnt;
      logic [3:0]   below_cnt;
      logic         above_flag;
      logic         below_flag;
      logic [2:0]   irq_status;
      logic [2:0]   irq_mask;
   } ltl_state_t;

endpackage : ltl_pkg

// ---- core/ltl_regs.sv ----
// Summary of operation
// - Lower threshold at index 02h, read/write, sets the lower comparison limit.
// - Lower threshold: exponent in bits 15:12, binary mantissa in bits 11:0.
// - Lower threshold resets to exponent 0h and mantissa 000h.
// - Threshold lux equals 0.01 times two to the exponent times mantissa.
// - Exponents 0 to 11 span 40.95 to 83865.60 lux, step doubling per code.
// - Result and both thresholds are compared on one common scale.
// - Upper threshold at index 03h, read/write, sets the upper comparison limit.
// - Upper threshold has the same format, resetting to exponent Bh, mantissa FFFh.
// - Comparisons use the true result exponent, even with exponent masking on.
// - Read-only maker word at index 7Eh; writes do nothing.
// - Read-only part word at index 7Fh; writes do nothing.
// - Above flag sets after the selected count of results above upper threshold.
// - Below flag sets after the selected count of results below lower threshold.
// - Fault count codes 00 to 11 select one, two, four or eight events.
// - Latch 0 makes flags follow comparison; latch 1 holds them until cleared.
`timescale 1ns/10ps

module ltl_regs
   import ltl_pkg::*;
#(
   // Both identification values are arbitrary.
   parameter logic [15:0] MAKER_WORD = 16'hA5A5,
   parameter logic [15:0] PART_WORD  = 16'h0123
)
(
   // Clock and reset
   input  wire logic        ref_clk,
   input  wire logic        nrst,
   // Avalon-MM slave
   input  wire logic [8:0]  address,
   input  wire logic        read,
   input  wire logic        write,
   input  wire logic [3:0]  byteenable,
   input  wire logic [31:0] writedata,
   output logic [31:0]      readdata,
   output logic             waitrequest,
   // Conversion core
   input  wire logic        result_valid,
   input  wire logic [3:0]  result_exponent,
   input  wire logic [11:0] result_mantissa,
   // Reporting
   output logic             above_flag,
   output logic             below_flag,
   output logic             alert_level,
   output logic             irq
);

   `include "ltl_params.svh"

   ////////////////////////////////////////////////////////////////////////////////////////////////

   ltl_state_t s;
   ltl_state_t next_s;

   // A mantissa scaled by its exponent; codes past eleven have no defined scale, so they pin to the top.
   function automatic logic [22:0] ltl_mag(input logic [3:0] exponent, input logic [11:0] mantissa);
      logic [22:0] wide;
      wide = {11'h000, mantissa};
      if (exponent > `LTL_MAX_EXP)
      begin
         ltl_mag = `LTL_FULL_SCALE;
      end
      else
      begin
         ltl_mag = wide << exponent;
      end
   endfunction : ltl_mag

   // A consecutive-hit counter held at its ceiling, so raising the fault count mid-streak keeps the true run.
   function automatic logic [3:0] ltl_count(input logic hit, input logic [3:0] cnt, input logic [3:0] need);
      if (!hit)
      begin
         ltl_count = 4'h0;
      end
      else if (cnt < need)
      begin
         ltl_count = cnt + 4'h1;
      end
      else
      begin
         ltl_count = cnt;
      end
   endfunction : ltl_count

   ////////////////////////////////////////////////////////////////////////////////////////////////

   logic [22:0] result_mag;
   logic [22:0] lower_mag;
   logic [22:0] upper_mag;
   logic [6:0]  index;
   logic        latch_mode;
   logic [3:0]  need;
   logic        above_hit;
   logic        below_hit;
   logic        above_reach;
   logic        below_reach;
   logic        rd_take;
   logic        wr_take;
   logic        flag_clear;
   logic [15:0] wr_word;
   logic [15:0] wr_lanes;
   logic [15:0] result_view;
   logic [31:0] rd_value;

   assign index       = address[8:2];
   assign latch_mode  = s.config_word[`LTL_CFG_LATCH_BIT];
   assign need        = 4'h1 << s.config_word[`LTL_CFG_FC_MSB:`LTL_CFG_FC_LSB];
   // The raw input exponent feeds the comparison; masking only touches what software reads.
   assign result_mag  = ltl_mag(result_exponent, result_mantissa);
   assign lower_mag   = ltl_mag(s.lower_threshold[`LTL_EXP_MSB:`LTL_EXP_LSB],
                                s.lower_threshold[`LTL_MAN_MSB:`LTL_MAN_LSB]);
   assign upper_mag   = ltl_mag(s.upper_threshold[`LTL_EXP_MSB:`LTL_EXP_LSB],
                                s.upper_threshold[`LTL_MAN_MSB:`LTL_MAN_LSB]);
   assign above_hit   = result_mag > upper_mag;
   assign below_hit   = result_mag < lower_mag;
   // A reach needs a valid result, so a threshold write alone never raises a flag.
   assign above_reach = result_valid && above_hit && (ltl_count(above_hit, s.above_cnt, `LTL_MAX_FAULTS) >= need);
   assign below_reach = result_valid && below_hit && (ltl_count(below_hit, s.below_cnt, `LTL_MAX_FAULTS) >= need);
   assign rd_take     = (s.bus == LTL_BUS_ACK) && read;
   assign wr_take     = (s.bus == LTL_BUS_ACK) && write;
   // Only the completing cycle of a read clears, so an event landing in the read's wait cycle is cleared without reaching the read data.
   assign flag_clear  = rd_take && (index == `LTL_IDX_CONFIG);
   assign wr_lanes    = {{8{byteenable[1]}}, {8{byteenable[0]}}};
   assign wr_word     = writedata[15:0];

   always_comb
   begin
      result_view = s.result;
      if (s.config_word[`LTL_CFG_MASK_BIT] &&
          (s.config_word[`LTL_CFG_RANGE_MSB:`LTL_CFG_RANGE_LSB] < `LTL_MASK_RANGE_LIMIT))
      begin
         result_view[`LTL_EXP_MSB:`LTL_EXP_LSB] = 4'h0;
      end
   end

   always_comb
   begin
      rd_value = 32'h00000000;
      if (index == `LTL_IDX_RESULT)
      begin
         rd_value[15:0] = result_view;
      end
      else if (index == `LTL_IDX_CONFIG)
      begin
         rd_value[15:0] = s.config_word;
         rd_value[`LTL_CFG_ABOVE_BIT] = s.above_flag;
         rd_value[`LTL_CFG_BELOW_BIT] = s.below_flag;
      end
      else if (index == `LTL_IDX_LOWER)
      begin
         rd_value[15:0] = s.lower_threshold;
      end
      else if (index == `LTL_IDX_UPPER)
      begin
         rd_value[15:0] = s.upper_threshold;
      end
      else if (index == `LTL_IDX_IRQ_STATUS)
      begin
         rd_value[2:0] = s.irq_status;
      end
      else if (index == `LTL_IDX_IRQ_MASK)
      begin
         rd_value[2:0] = s.irq_mask;
      end
      else if (index == `LTL_IDX_MAKER)
      begin
         rd_value[15:0] = MAKER_WORD;
      end
      else if (index == `LTL_IDX_PART)
      begin
         rd_value[15:0] = PART_WORD;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////////////

   always_comb
   begin
      next_s = s;
      // Bus: every access waits exactly one cycle so the read value comes from a flip-flop.
      case (s.bus)
         LTL_BUS_IDLE:
         begin
            if (read || write)
            begin
               next_s.bus      = LTL_BUS_ACK;
               next_s.readdata = read ? rd_value : 32'h00000000;
            end
         end
         LTL_BUS_ACK:
         begin
            next_s.bus = LTL_BUS_IDLE;
         end
         default:
         begin
            next_s.bus = LTL_BUS_IDLE;
         end
      endcase

      // Writes; identification words and unmapped indices ignore them.
      if (wr_take)
      begin
         if (index == `LTL_IDX_CONFIG)
         begin
            next_s.config_word = (s.config_word & ~(wr_lanes & `LTL_CFG_WRITE_MASK)) |
                                 (wr_word & wr_lanes & `LTL_CFG_WRITE_MASK);
         end
         else if (index == `LTL_IDX_LOWER)
         begin
            next_s.lower_threshold = (s.lower_threshold & ~wr_lanes) | (wr_word & wr_lanes);
         end
         else if (index == `LTL_IDX_UPPER)
         begin
            next_s.upper_threshold = (s.upper_threshold & ~wr_lanes) | (wr_word & wr_lanes);
         end
         else if (index == `LTL_IDX_IRQ_STATUS)
         begin
            next_s.irq_status = s.irq_status & ~(writedata[2:0] & {3{byteenable[0]}});
         end
         else if (index == `LTL_IDX_IRQ_MASK)
         begin
            if (byteenable[0])
            begin
               next_s.irq_mask = writedata[2:0];
            end
         end
      end

      // Latched flags drop on a read of the configuration word; a new event in that cycle wins.
      if (flag_clear && latch_mode)
      begin
         next_s.above_flag = 1'b0;
         next_s.below_flag = 1'b0;
      end

      if (result_valid)
      begin
         next_s.result    = {result_exponent, result_mantissa};
         next_s.above_cnt = ltl_count(above_hit, s.above_cnt, `LTL_MAX_FAULTS);
         next_s.below_cnt = ltl_count(below_hit, s.below_cnt, `LTL_MAX_FAULTS);
         if (latch_mode)
         begin
            next_s.above_flag = next_s.above_flag | above_reach;
            next_s.below_flag = next_s.below_flag | below_reach;
         end
         else
         begin
            next_s.above_flag = above_reach;
            next_s.below_flag = below_reach;
         end
      end

      // Sticky interrupt events are applied after the clear so they win over it.
      if (above_reach)
      begin
         next_s.irq_status[`LTL_IRQ_ABOVE_BIT] = 1'b1;
      end
      if (below_reach)
      begin
         next_s.irq_status[`LTL_IRQ_BELOW_BIT] = 1'b1;
      end
      if (result_valid)
      begin
         next_s.irq_status[`LTL_IRQ_DONE_BIT] = 1'b1;
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (!nrst)
      begin
         s                 <= '0;
         s.bus             <= LTL_BUS_IDLE;
         s.lower_threshold <= `LTL_LOWER_RESET;
         s.upper_threshold <= `LTL_UPPER_RESET;
         s.config_word     <= `LTL_CONFIG_RESET;
      end
      else
      begin
         s <= next_s;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////////////

   assign readdata    = s.readdata;
   // Waitrequest is combinational so that the single wait state adds no cycle of its own.
   assign waitrequest = (read || write) && (s.bus != LTL_BUS_ACK);
   assign above_flag  = s.above_flag;
   assign below_flag  = s.below_flag;
   // Polarity 0 drives the alert low while a flag is up.
   assign alert_level = s.config_word[`LTL_CFG_POL_BIT] ? (s.above_flag || s.below_flag)
                                                        : !(s.above_flag || s.below_flag);
   // The interrupt is a plain level; software drops it by writing ones to the status word.
   assign irq         = |(s.irq_status & s.irq_mask);

endmodule : ltl_regs

// ---- verification/ltl_props.sv ----
`timescale 1ns/10ps
module ltl_props
   import ltl_pkg::*;
#(
   parameter logic [15:0] MAKER_WORD = 16'hA5A5,
   parameter logic [15:0] PART_WORD  = 16'h0123
)
(
   // Clock and reset
   input wire logic        ref_clk,
   input wire logic        nrst,
   // Register bus
   input wire logic [8:0]  address,
   input wire logic        read,
   input wire logic        write,
   input wire logic [3:0]  byteenable,
   input wire logic [31:0] writedata,
   input wire logic [31:0] readdata,
   input wire logic        waitrequest,
   // Conversion and reporting
   input wire logic        result_valid,
   input wire logic [3:0]  result_exponent,
   input wire logic [11:0] result_mantissa,
   input wire logic        above_flag,
   input wire logic        below_flag,
   input wire logic        alert_level,
   input wire logic        irq
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!nrst);
   ////////////////////////////////////////////////////////////
   sequence s_req; (read || write) && waitrequest; endsequence
   sequence s_rd(logic [6:0] idx); read && !waitrequest && address[8:2] == idx; endsequence
   property p_ack; s_req |=> !waitrequest; endproperty
   property p_hi_zero; read && !waitrequest |-> readdata[31:16] == 16'h0000; endproperty
   property p_maker; s_rd(7'h7E) |-> readdata[15:0] == MAKER_WORD; endproperty
   property p_part; s_rd(7'h7F) |-> readdata[15:0] == PART_WORD; endproperty
   // A zero result can only pass the upper limit through a saturated exponent.
   property p_above; $rose(above_flag) |->
      $past(result_valid && (result_mantissa != 12'h000 || result_exponent > 4'hB)); endproperty
   property p_below; $rose(below_flag) |-> $past(result_valid && result_exponent < 4'hC); endproperty
   property p_hold; $changed(above_flag) || $changed(below_flag) |->
      $past(result_valid || ((read || write) && !waitrequest && address[8:2] == 7'h01)); endproperty
   property p_alert; $changed(alert_level) && $stable(above_flag) && $stable(below_flag) |->
      $past(write && !waitrequest && address[8:2] == 7'h01); endproperty
   ////////////////////////////////////////////////////////////
   a_ack: assert property (p_ack) else $error("bus wait longer than one cycle");
   a_hi_zero: assert property (p_hi_zero) else $error("read data upper half not zero");
   a_maker: assert property (p_maker) else $error("maker word wrong");
   a_part: assert property (p_part) else $error("part word wrong");
   a_above: assert property (p_above) else $error("above flag rose without cause");
   a_below: assert property (p_below) else $error("below flag rose without cause");
   a_hold: assert property (p_hold) else $error("flag moved without result or clear");
   a_alert: assert property (p_alert) else $error("alert moved without cause");
endmodule : ltl_props

bind ltl_regs ltl_props #(.MAKER_WORD(MAKER_WORD), .PART_WORD(PART_WORD)) u_props (
   .ref_clk(ref_clk), .nrst(nrst), .address(address), .read(read), .write(write),
   .byteenable(byteenable), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
   .result_valid(result_valid), .result_exponent(result_exponent), .result_mantissa(result_mantissa),
   .above_flag(above_flag), .below_flag(below_flag), .alert_level(alert_level), .irq(irq));

// ---- verification/ltl_host_model.sv ----
`timescale 1ns/10ps
module ltl_host_model
(
   // Clock
   input  wire logic        ref_clk,
   // Register bus master
   output logic [8:0]       address,
   output logic             read,
   output logic             write,
   output logic [3:0]       byteenable,
   output logic [31:0]      writedata,
   input  wire logic [31:0] readdata,
   input  wire logic        waitrequest
);
   initial
   begin
      address = 9'h000;
      read = 1'b0;
      write = 1'b0;
      byteenable = 4'h0;
      writedata = 32'h00000000;
   end
   ////////////////////////////////////////////////////////////
   // Waitrequest and read data are taken at the rising edge itself, before that edge's updates land.
   task automatic xfer(input logic [6:0] idx, input logic we, input logic [15:0] d,
                       input logic [3:0] be, output logic [31:0] q);
      @(posedge ref_clk);
      address <= {idx, 2'b00};
      read <= !we;
      write <= we;
      byteenable <= be;
      writedata <= {~d, d};
      do @(posedge ref_clk); while (waitrequest !== 1'b0);
      q = readdata;
      read <= 1'b0;
      write <= 1'b0;
      address <= ~address;
      writedata <= ~writedata;
   endtask : xfer
   task automatic set_limits(input logic [3:0] rng, input logic [11:0] lo_m, input logic [11:0] hi_m);
      logic [31:0] q;
      xfer(7'h02, 1'b1, {rng, lo_m}, 4'hF, q);
      xfer(7'h03, 1'b1, {rng, hi_m}, 4'hF, q);
   endtask : set_limits
endmodule : ltl_host_model

// ---- verification/light_threshold_limit_registers_tb_top.sv ----
`timescale 1ns/10ps
module light_threshold_limit_registers_tb_top;
   import ltl_pkg::*;
   localparam logic [15:0] MW = 16'h3C5A; // Arbitrary value.
   localparam logic [15:0] PW = 16'h0E71; // Arbitrary value.
   logic        ref_clk = 1'b0;
   logic        nrst = 1'b0;
   logic [8:0]  address;
   logic        read, write, waitrequest, above_flag, below_flag, alert_level, irq;
   logic [3:0]  byteenable;
   logic [31:0] writedata, readdata, q;
   logic        result_valid = 1'b0;
   logic [3:0]  result_exponent = 4'h0;
   logic [11:0] result_mantissa = 12'h000;
   logic [15:0] m_lo = 16'h0000, m_up = 16'hBFFF, m_cfg = 16'hC010, m_res = 16'h0000;
   logic [2:0]  m_st = 3'h0, m_mk = 3'h0;
   logic        fa = 1'b0, fb = 1'b0;
   logic [6:0]  ids [9] = '{7'h02, 7'h03, 7'h01, 7'h7E, 7'h7F, 7'h10, 7'h11, 7'h00, 7'h20};
   int          ca = 0, cb = 0, n_fail = 0, num_checks = 0;

   always #5 ref_clk = ~ref_clk;

   ltl_regs #(.MAKER_WORD(MW), .PART_WORD(PW)) dut (.ref_clk(ref_clk), .nrst(nrst), .address(address),
      .read(read), .write(write), .byteenable(byteenable), .writedata(writedata), .readdata(readdata),
      .waitrequest(waitrequest), .result_valid(result_valid), .result_exponent(result_exponent),
      .result_mantissa(result_mantissa), .above_flag(above_flag), .below_flag(below_flag),
      .alert_level(alert_level), .irq(irq));
   ltl_host_model host (.ref_clk(ref_clk), .address(address), .read(read), .write(write),
      .byteenable(byteenable), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest));
   ////////////////////////////////////////////////////////////
   function automatic int mag(input logic [15:0] v);
      return (v[15:12] > 4'hB) ? 32'h7FFFFF : int'(v[11:0]) << v[15:12];
   endfunction : mag
   task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         n_fail++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk_reg
   task automatic chk_pin(input logic [3:0] got, input logic [3:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         n_fail++;
         $display("[ERR] t=%0t pins=%h exp=%h", $time, got, exp);
      end
   endtask : chk_pin
   task automatic pins();
      logic [3:0] e;
      @(negedge ref_clk);
      e = {fa, fb, |(m_st & m_mk), m_cfg[3] ~^ (fa | fb)};
      chk_pin({above_flag, below_flag, irq, alert_level}, e);
   endtask : pins
   task automatic rd(input logic [6:0] idx);
      logic [15:0] e;
      case (idx)
         7'h00: e = m_res;
         7'h01: e = (m_cfg & 16'hF01F) | {9'h000, fa, fb, 5'h00};
         7'h02: e = m_lo;
         7'h03: e = m_up;
         7'h10: e = {13'h0000, m_st};
         7'h11: e = {13'h0000, m_mk};
         7'h7E: e = MW;
         7'h7F: e = PW;
         default: e = 16'h0000;
      endcase
      host.xfer(idx, 1'b0, 16'h0000, 4'hF, q);
      chk_reg(q, {16'h0000, e});
      // Reading the configuration word is the clearing event of the latched mode.
      if (idx == 7'h01 && m_cfg[4])
      begin
         fa = 1'b0;
         fb = 1'b0;
      end
   endtask : rd
   task automatic wr(input logic [6:0] idx, input logic [15:0] d, input logic [3:0] be);
      logic [15:0] o;
      host.xfer(idx, 1'b1, d, be, q);
      o = (idx == 7'h02) ? m_lo : (idx == 7'h03) ? m_up : (idx == 7'h01) ? m_cfg : {13'h0000, m_mk};
      o = {be[1] ? d[15:8] : o[15:8], be[0] ? d[7:0] : o[7:0]};
      case (idx)
         7'h01: m_cfg = o & 16'hF01F;
         7'h02: m_lo = o;
         7'h03: m_up = o;
         7'h10: m_st = m_st & ~(be[0] ? d[2:0] : 3'h0);
         7'h11: m_mk = o[2:0];
         default: ;
      endcase
   endtask : wr
   task automatic res(input logic [3:0] e, input logic [11:0] m);
      int r, need;
      @(posedge ref_clk);
      result_valid <= 1'b1;
      result_exponent <= e;
      result_mantissa <= m;
      @(posedge ref_clk);
      result_valid <= 1'b0;
      r = mag({e, m});
      need = 1 << m_cfg[1:0];
      ca = (r > mag(m_up)) ? ((ca < 8) ? ca + 1 : 8) : 0;
      cb = (r < mag(m_lo)) ? ((cb < 8) ? cb + 1 : 8) : 0;
      fa = (m_cfg[4] & fa) | (ca >= need);
      fb = (m_cfg[4] & fb) | (cb >= need);
      m_st = m_st | {1'b1, cb >= need, ca >= need};
      m_res = (m_cfg[2] && m_cfg[15:12] < 4'hC) ? {4'h0, m} : {e, m};
      pins();
   endtask : res
   task automatic conclude();
      $display("checks=%0d fails=%0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : conclude
   ////////////////////////////////////////////////////////////
   initial
   begin
      #100000;
      n_fail++;
      conclude();
   end
   initial
   begin
      void'($urandom(32'h84F39FFD));
      repeat (2) @(posedge ref_clk);
      nrst <= 1'b1;
      foreach (ids[i]) rd(ids[i]);
      wr(7'h7E, 16'h0000, 4'hF);
      wr(7'h7F, 16'hFFFF, 4'hF);
      repeat (4)
      begin
         wr(7'h02, 16'($urandom), 4'($urandom));
         wr(7'h03, 16'($urandom), 4'($urandom));
         foreach (ids[i]) rd(ids[i]);
      end
      // A second reset must bring both thresholds back from whatever was written.
      @(posedge ref_clk);
      nrst <= 1'b0;
      repeat (2) @(posedge ref_clk);
      nrst <= 1'b1;
      m_lo = 16'h0000;
      m_up = 16'hBFFF;
      foreach (ids[i]) rd(ids[i]);
      for (int fc = 0; fc < 4; fc++)
      begin
         wr(7'h01, 16'hC000 | 16'(fc) | (16'(fc % 2) << 3), 4'hF);
         wr(7'h02, 16'h1100, 4'hF);
         wr(7'h03, 16'h2100, 4'hF);
         repeat ((1 << fc) + 1) res(4'h3, 12'hFFF);
         res(4'h0, 12'h300);
         repeat ((1 << fc) + 1) res(4'h0, 12'h010);
      end
      host.set_limits(4'h5, 12'h100, 12'hC00);
      m_lo = 16'h5100;
      m_up = 16'h5C00;
      wr(7'h01, 16'h5004, 4'hF);
      repeat (40)
      begin
         if ($urandom % 4 == 0)
            wr(7'h03, 16'($urandom), 4'hF);
         res(4'($urandom), 12'($urandom));
         rd(7'h00);
      end
      wr(7'h01, 16'hC011, 4'hF);
      wr(7'h03, 16'h2100, 4'hF);
      wr(7'h11, 16'h0001, 4'hF);
      wr(7'h10, 16'h0007, 4'h1);
      repeat (2) res(4'h3, 12'hFFF);
      res(4'h0, 12'h300);
      rd(7'h10);
      rd(7'h01);
      pins();
      wr(7'h10, 16'h0001, 4'h1);
      pins();
      wr(7'h11, 16'h0000, 4'hF);
      res(4'h3, 12'hFFF);
      rd(7'h10);
      conclude();
   end
endmodule : light_threshold_limit_registers_tb_top
